// file: hdl/lcd_cmd_consts.vh
// command codes, status layout and timing constants of the column driver command decoder
`ifndef LCD_CMD_CONSTS_VH
`define LCD_CMD_CONSTS_VH

// command codes (upper bits compared under mask; E0, EE and E2 compared whole)
`define CMD_DISPLAY_ONOFF   8'hAE
`define CMD_START_LINE      8'hC0
`define CMD_SET_PAGE        8'hB8
`define CMD_SEG_DIR         8'hA0
`define CMD_STATIC_DRIVE    8'hA4
`define CMD_SELECT_DUTY     8'hA8
`define CMD_RMW_ENTER       8'hE0
`define CMD_RMW_END         8'hEE
`define CMD_SOFT_RESET      8'hE2
`define MASK_BIT0           8'hFE
`define MASK_START_LINE     8'hE0
`define MASK_PAGE           8'hFC

// status bit positions
`define STAT_BUSY_BIT       7
`define STAT_SEGDIR_BIT     6
`define STAT_OFF_BIT        5
`define STAT_RESET_BIT      4

// address limits and reset values
`define COL_LAST            7'h4F
`define COL_STOP            7'h50
`define PAGE_AFTER_RESET    2'h3
`define START_LINE_RESET    5'h00

// busy time of one command, in ns, and software reset time
`define CMD_BUSY_NS         20
`define RESET_BUSY_NS       100
`define CLK_PERIOD_NS       5

`endif

// file: hdl/lcd_fifo.v
// small fifo carrying host write transfers into the command decoder
`timescale 1ns/1ps
module lcd_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	// clock and reset
	input  wire             sys_clk,
	input  wire             reset_n,
	// fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage has no reset; only pointers and count carry state
	always @(posedge sys_clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointer and occupancy update
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule // lcd_fifo

// file: hdl/lcd_ram.v
// display data memory with registered read port, 4 pages by 80 columns
`timescale 1ns/1ps
module lcd_ram #(
	parameter AW    = 9,
	parameter WORDS = 320
) (
	// clock
	input  wire          sys_clk,
	// host port
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [7:0]    wr_data,
	input  wire [AW-1:0] rd_addr,
	output reg  [7:0]    rd_data
);
	reg [7:0] mem [0:WORDS-1];

	// read data always comes out of a register
	always @(posedge sys_clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule // lcd_ram

// file: hdl/lcd_column_driver.v
// command decoder and display memory access of one column driver half
// timing, in sys_clk cycles
// - pins pass two flip-flops, so each enable edge acts three cycles late
// - reads answer on the synchronised rising enable
// - writes queue on the synchronised falling enable, once data has settled
// - commands wait in the fifo while busy; data bytes wait only behind such a command or a read
// - a write meeting a full fifo is lost: the bus has no wait line
// - a command keeps busy for CMD_CYCLES, a reset for RESET_CYCLES
// - ram pages sit 128 words apart, so the address needs no multiplier
// - column 80 of each page is never written; 81 to 127 only after a direct column set
//
`timescale 1ns/1ps
`include "lcd_cmd_consts.vh"
module lcd_column_driver #(
	parameter FIFO_DEPTH = 4
) (
	// clock and reset
	input  wire       sys_clk,
	input  wire       reset_n,
	// host bus pins
	input  wire       chip_enable,
	input  wire       cmd_data_select,
	input  wire       read_not_write,
	input  wire [7:0] data_in,
	output reg  [7:0] data_out,
	output reg        data_oe_n,
	// display drive state
	output reg        display_on,
	output reg  [4:0] first_common_line,
	output reg        duty_32,
	output reg        all_commons_selected,
	output reg        first_segment_output_last,
	output reg  [4:0] line_scan
);
	localparam CMD_CYCLES   = (`CMD_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam RESET_CYCLES = (`RESET_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// pin synchronisers and strobe edge
	// ------------------------------------------------------------
	reg  [1:0] en_sync;
	reg  [1:0] sel_sync;
	reg  [1:0] rw_sync;
	reg  [7:0] din_meta;
	reg  [7:0] din_sync;
	reg        en_prev;
	wire       strobe_start;
	wire       strobe_end;

	// two stages before any logic looks at a pin
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			en_sync  <= 2'h0;
			sel_sync <= 2'h0;
			rw_sync  <= 2'h0;
			din_meta <= 8'h00;
			din_sync <= 8'h00;
			en_prev  <= 1'b0;
		end else begin
			en_sync  <= {en_sync[0], chip_enable};
			sel_sync <= {sel_sync[0], cmd_data_select};
			rw_sync  <= {rw_sync[0], read_not_write};
			din_meta <= data_in;
			din_sync <= din_meta;
			en_prev  <= en_sync[1];
		end
	end

	assign strobe_start = en_sync[1] & ~en_prev;
	// writes are taken on the falling enable, when data has long settled
	assign strobe_end   = ~en_sync[1] & en_prev;

	// ------------------------------------------------------------
	// write transfer fifo
	// ------------------------------------------------------------
	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire [9:0] fifo_out_data;
	reg        take;
	wire       wr_push;

	assign wr_push = strobe_end & ~rw_sync[1];
	lcd_fifo #(
		.WIDTH (10),
		.DEPTH (FIFO_DEPTH),
		.AW    (2)
	) u_fifo (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.in_valid  (wr_push),
		.in_ready  (fifo_in_ready),
		.in_data   ({1'b0, sel_sync[1], din_sync}),
		.out_valid (fifo_out_valid),
		.out_ready (take),
		.out_data  (fifo_out_data)
	);

	// ------------------------------------------------------------
	// control state
	// ------------------------------------------------------------
	// host addressing and modes
	reg  [6:0] column;
	reg  [6:0] saved_column;
	reg  [1:0] page;
	reg        rmw_mode;
	reg        seg_inverted;
	reg        static_drive;
	reg        disp_on_bit;
	// busy and reset tracking
	reg  [7:0] busy_count;
	reg        reset_busy;
	// data latch and ram port
	reg  [7:0] io_latch;
	reg        latch_load;
	reg        ram_we;
	reg  [7:0] ram_wdata;
	reg  [8:0] ram_waddr;
	wire [7:0] ram_rdata;
	wire [8:0] ram_addr;
	// decoded views of the queue head and status
	wire       busy;
	wire       host_read_data;
	wire       is_cmd;
	wire [7:0] byte_in;
	wire [7:0] driver_status;

	// busy only stalls commands; a full fifo drops the write
	// since the host gets no wait signal on this bus
	assign busy     = (busy_count != 8'h00);
	assign is_cmd   = ~fifo_out_data[8];
	assign byte_in  = fifo_out_data[7:0];
	assign ram_addr = {page, column};
	assign host_read_data = strobe_start & rw_sync[1] & sel_sync[1];

	// status byte, rebuilt every cycle from the live flags
	assign driver_status = {busy, ~seg_inverted, ~disp_on_bit, reset_busy,
		4'h0};

	// commands wait while busy; data entries at the head drain in any cycle without a read strobe
	always @* begin
		take = fifo_out_valid & ~(is_cmd & busy) & ~host_read_data;
	end

	// 128-word page stride: page and column simply concatenate, unused words traded for it
	lcd_ram #(
		.AW    (9),
		.WORDS (512)
	) u_ram (
		.sys_clk (sys_clk),
		.wr_en   (ram_we),
		.wr_addr (ram_waddr),
		.wr_data (ram_wdata),
		.rd_addr (ram_addr),
		.rd_data (ram_rdata)
	);

	// ------------------------------------------------------------
	// command decode and data access
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			column       <= 7'h00;
			saved_column <= 7'h00;
			page         <= `PAGE_AFTER_RESET;
			rmw_mode     <= 1'b0;
			seg_inverted <= 1'b0;
			static_drive <= 1'b0;
			disp_on_bit  <= 1'b0;
			duty_32      <= 1'b1;
			first_common_line <= `START_LINE_RESET;
			busy_count   <= RESET_CYCLES[7:0];
			reset_busy   <= 1'b1;
			ram_we       <= 1'b0;
			ram_wdata    <= 8'h00;
			ram_waddr    <= 9'h000;
			latch_load   <= 1'b0;
			io_latch     <= 8'h00;
		end else begin
			ram_we     <= 1'b0;
			latch_load <= 1'b0;
			if (busy)
				busy_count <= busy_count - 8'h01;
			else
				reset_busy <= 1'b0;
			// the ram output one cycle on holds the addressed byte
			if (latch_load)
				io_latch <= ram_rdata;
			// a read strobe wins over a queued entry in that cycle
			if (host_read_data) begin
				latch_load <= 1'b1;
				if (!rmw_mode && column != `COL_STOP)
					column <= column + 7'h01;
			end else if (take && !is_cmd) begin
				ram_we    <= (column != `COL_STOP);
				ram_wdata <= byte_in;
				// address captured with the data, before the column steps
				ram_waddr <= ram_addr;
				if (column != `COL_STOP)
					column <= column + 7'h01;
			end else if (take) begin
				busy_count <= CMD_CYCLES[7:0];
				if (!byte_in[7]) begin
					column <= byte_in[6:0];
				end else if ((byte_in & `MASK_BIT0) == `CMD_DISPLAY_ONOFF) begin
					disp_on_bit <= byte_in[0];
				end else if ((byte_in & `MASK_START_LINE) == `CMD_START_LINE) begin
					first_common_line <= byte_in[4:0];
				end else if ((byte_in & `MASK_PAGE) == `CMD_SET_PAGE) begin
					page <= byte_in[1:0];
				end else if ((byte_in & `MASK_BIT0) == `CMD_SEG_DIR) begin
					seg_inverted <= byte_in[0];
				end else if ((byte_in & `MASK_BIT0) == `CMD_STATIC_DRIVE) begin
					static_drive <= byte_in[0];
				end else if ((byte_in & `MASK_BIT0) == `CMD_SELECT_DUTY) begin
					duty_32 <= byte_in[0];
				end else if (byte_in == `CMD_RMW_ENTER) begin
					rmw_mode     <= 1'b1;
					saved_column <= column;
				end else if (byte_in == `CMD_RMW_END) begin
					rmw_mode <= 1'b0;
					if (rmw_mode)
						column <= saved_column;
				end else if (byte_in == `CMD_SOFT_RESET) begin
					first_common_line <= `START_LINE_RESET;
					page              <= `PAGE_AFTER_RESET;
					busy_count        <= RESET_CYCLES[7:0];
					reset_busy        <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// host read bus: status or latched data
	// ------------------------------------------------------------
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_out  <= 8'h00;
			data_oe_n <= 1'b1;
		end else begin
			if (strobe_start && rw_sync[1]) begin
				data_oe_n <= 1'b0;
				if (sel_sync[1])
					data_out <= io_latch;
				else
					data_out <= driver_status;
			end else if (!en_sync[1] || !rw_sync[1]) begin
				data_oe_n <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// panel drive state and line scan
	// ------------------------------------------------------------
	reg [4:0] scan_offset;

	// scan walks duty lines upward from the start line
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			display_on                <= 1'b0;
			all_commons_selected      <= 1'b0;
			first_segment_output_last <= 1'b0;
			scan_offset               <= 5'h00;
			line_scan                 <= 5'h00;
		end else begin
			display_on                <= disp_on_bit | static_drive;
			all_commons_selected      <= static_drive;
			first_segment_output_last <= seg_inverted;
			// 1/16 duty folds the offset back after line 15
			if (!duty_32 && scan_offset == 5'h0F)
				scan_offset <= 5'h00;
			else
				scan_offset <= scan_offset + 5'h01;
			line_scan <= first_common_line + scan_offset;
		end
	end
endmodule // lcd_column_driver

// file: bench/lcd_host_model.sv
// host processor model driving the column driver bus
`timescale 1ns/1ps
module lcd_host_model (
	// clock
	input  wire       sys_clk,
	// bus towards the driver
	output reg        chip_enable,
	output reg        cmd_data_select,
	output reg        read_not_write,
	output reg  [7:0] data_in,
	input  wire [7:0] data_out,
	input  wire       data_oe_n
);
	// idle bus at time zero
	initial begin
		chip_enable = 1'b0;
		cmd_data_select = 1'b0;
		read_not_write = 1'b1;
		data_in = 8'h00;
	end
	// one strobe; a read returns X unless the driver really drives
	task xfer(input sel, input rnw, input [7:0] wd, input integer gap, output [7:0] rd);
		begin
			@(negedge sys_clk);
			cmd_data_select = sel;
			read_not_write = rnw;
			data_in = rnw ? ~data_in : wd;
			repeat (4) @(negedge sys_clk);
			chip_enable = 1'b1;
			repeat (24) @(negedge sys_clk);
			rd = data_oe_n ? 8'hXX : data_out;
			chip_enable = 1'b0;
			repeat (4) @(negedge sys_clk);
			// released lines never show the last value
			data_in = ~data_in;
			repeat (gap) @(negedge sys_clk);
		end
	endtask
endmodule // lcd_host_model

// file: bench/lcd_column_driver_chk.sv
// assertions on the column driver ports
`timescale 1ns/1ps
module lcd_column_driver_chk (
	// clock and reset
	input wire       sys_clk,
	input wire       reset_n,
	// watched pins
	input wire       chip_enable,
	input wire       read_not_write,
	input wire [7:0] data_out,
	input wire       data_oe_n,
	input wire       display_on,
	input wire [4:0] first_common_line,
	input wire       duty_32,
	input wire       all_commons_selected,
	input wire       first_segment_output_last,
	input wire [4:0] line_scan
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_oe_only_read: assert property ($fell(data_oe_n) |-> chip_enable && read_not_write)
		else $error("bus driven outside a read");
	a_oe_release: assert property (!chip_enable [*6] |-> data_oe_n)
		else $error("bus not released");
	a_oe_hold: assert property ($fell(data_oe_n) |=> !data_oe_n [*8])
		else $error("read drive dropped early");
	a_out_on_read: assert property ($changed(data_out) |-> $fell(data_oe_n))
		else $error("read byte moved outside a read");
	a_static_on: assert property (all_commons_selected |-> display_on)
		else $error("static drive without display on");
	a_cfg_after_write: assert property (($changed(display_on) || $changed(duty_32)
		|| $changed(first_segment_output_last) || $changed(first_common_line))
		|-> !$past(chip_enable, 3))
		else $error("setting moved during a strobe");
	a_duty_reset: assert property ($rose(reset_n) |-> duty_32)
		else $error("duty not 1/32 after reset");
	a_scan_step: assert property (line_scan == $past(line_scan)
		|| line_scan == $past(line_scan) + 5'h01 || line_scan == first_common_line
		|| first_common_line != $past(first_common_line, 2))
		else $error("scan line jumped");
endmodule // lcd_column_driver_chk
bind lcd_column_driver lcd_column_driver_chk lcd_column_driver_chk_inst (.sys_clk(sys_clk),
	.reset_n(reset_n), .chip_enable(chip_enable), .read_not_write(read_not_write),
	.data_out(data_out), .data_oe_n(data_oe_n), .display_on(display_on),
	.first_common_line(first_common_line), .duty_32(duty_32),
	.all_commons_selected(all_commons_selected),
	.first_segment_output_last(first_segment_output_last), .line_scan(line_scan));

// file: bench/lcd_column_driver_tb.sv
// self-checking bench for the column driver
`timescale 1ns/1ps
module lcd_column_driver_tb;
	reg        sys_clk;
	reg        reset_n;
	wire       ce, sel, rnw, oe_n, on, duty, allc, segl;
	wire [7:0] din;
	wire [7:0] dout;
	wire [4:0] fcl;
	wire [4:0] scan;
	integer    n_errors;
	integer    checked;
	integer    i;
	reg  [7:0] r;
	reg  [7:0] p;
	// -----------------------------
	// instances
	// -----------------------------
	lcd_host_model lcd_host_model_inst (.sys_clk(sys_clk), .chip_enable(ce),
		.cmd_data_select(sel), .read_not_write(rnw), .data_in(din), .data_out(dout),
		.data_oe_n(oe_n));
	lcd_column_driver lcd_column_driver_inst (.sys_clk(sys_clk), .reset_n(reset_n),
		.chip_enable(ce), .cmd_data_select(sel), .read_not_write(rnw), .data_in(din),
		.data_out(dout), .data_oe_n(oe_n), .display_on(on), .first_common_line(fcl),
		.duty_32(duty), .all_commons_selected(allc), .first_segment_output_last(segl),
		.line_scan(scan));
	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// -----------------------------
	// tasks
	// -----------------------------
	task check(input [7:0] seen, input [7:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// host cycle kept above the 1000 ns minimum
	task wr(input s, input [7:0] v);
		lcd_host_model_inst.xfer(s, 1'b0, v, 170, r);
	endtask
	task rd(input s);
		lcd_host_model_inst.xfer(s, 1'b1, 8'h00, 170, r);
	endtask
	task test_done;
		begin
			$display("errors %0d checks %0d", n_errors, checked);
			if (n_errors == 0 && checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// watchdog against a hung run
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_errors = n_errors + 1;
		test_done;
	end
	// -----------------------------
	// main sequence
	// -----------------------------
	initial begin
		n_errors = 0;
		checked = 0;
		reset_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		rd(0); check(r, 8'hF0);
		rd(0); check(r, 8'h60);
		wr(0, 8'hAF); rd(0); check(r, 8'h40);
		check({7'h00, on}, 8'h01);
		wr(0, 8'hA1); rd(0); check(r, 8'h00);
		check({7'h00, segl}, 8'h01);
		wr(0, 8'hA0); wr(0, 8'hA5); wr(0, 8'hAE);
		check({6'h00, allc, on}, 8'h03);
		wr(0, 8'hA4); check({6'h00, allc, on}, 8'h00);
		wr(0, 8'hA8); check({7'h00, duty}, 8'h00);
		r = {3'h0, scan};
		repeat (16) @(negedge sys_clk);
		check({3'h0, scan}, r);
		wr(0, 8'hA9); check({7'h00, duty}, 8'h01);
		wr(0, 8'hDF); check({3'h0, fcl}, 8'h1F);
		r = {3'h0, scan};
		@(negedge sys_clk);
		check({3'h0, scan}, {3'h0, r[4:0] + 5'h01});
		// descending pages expose any page step or column wrap
		for (i = 3; i >= 0; i = i - 1) begin
			p = i;
			wr(0, 8'hB8 | p); wr(0, 8'h00); wr(1, 8'h10 + p);
			wr(0, 8'h4F); wr(1, 8'h20 + p); wr(1, 8'h30 + p); wr(1, 8'h40 + p);
		end
		for (i = 0; i < 4; i = i + 1) begin
			p = i;
			wr(0, 8'hB8 | p); wr(0, 8'h00); rd(1);
			rd(1); check(r, 8'h10 + p);
			wr(0, 8'h4F); rd(1);
			rd(1); check(r, 8'h20 + p);
		end
		wr(0, 8'hB8); wr(0, 8'h00); wr(0, 8'hE0); rd(1);
		rd(1); check(r, 8'h10);
		wr(1, 8'h77); wr(1, 8'h66); wr(0, 8'hEE); rd(1);
		rd(1); check(r, 8'h77);
		rd(1); check(r, 8'h66);
		lcd_host_model_inst.xfer(1'b0, 1'b0, 8'hE2, 4, r);
		rd(0); check(r, 8'hF0);
		check({3'h0, fcl}, 8'h00);
		wr(0, 8'h05); wr(1, 8'hA5); wr(0, 8'hBB); wr(0, 8'h00); rd(1);
		rd(1); check(r, 8'h13);
		wr(0, 8'h05); rd(1);
		rd(1); check(r, 8'hA5);
		test_done;
	end
endmodule // lcd_column_driver_tb
